//--- include/mcpwm_pkg.sv
/*
 * Constants, register layout and carrier types of the phase-shifted
 * sixteen channel PWM output block.
 * Assumes a serial-bus slave in the system clock domain that presents
 * decoded byte writes, the write acknowledge and the bus STOP.
 */
// Functional notes
// [R1] Invert setting 0 drives each output uninverted while enable is low.
// [R2] Invert setting 1 inverts every output while enable is low.
// [R3] Change select 0 applies new compare values at bus STOP.
// [R4] Change select 1 applies new compare values at the write acknowledge.
// [R5] Acknowledge mode changes a channel only after all four bytes load.
// [R6] STOP update covers bytes 06h to 45h, any number, any order.
// [R7] Drive type 0 gives open-drain outputs, 1 (default) totem-pole.
// [R8] With enable high, outputs follow the disabled-state field codes.
// [R9] After reset every channel output is held low.
// [R10] Every channel has its own on-count and off-count.
// [R11] On-count and off-count are 12-bit values from 0 to 4095.
// [R12] One shared 12-bit counter runs 0 to 0FFFh and wraps.
// [R13] Output asserts at the on-count and negates at the off-count.
// [R14] Phase and duty resolution is one counter step of 4096.
// [R15] On-count above off-count turns off in the next counter period.
// [R16] While the oscillator sleeps no channel output changes; the code holds the PWM levels, but oe_n_i and mode writes still act.
// [R17] Bit 4 of all-channel off high byte forces all channels off.
// [R18] Full-on bit forces output asserted; full-off bit has priority.
// [R19] Equal on and off counts without full bits keep output negated.
package mcpwm_pkg;
   // ==========================================================
   // Geometry
   // ==========================================================
   localparam int NUM_CH = 16;
   localparam int CNT_W = 12;
   localparam int BYTES_PER_CH = 4;
   localparam logic [11:0] CNT_LAST = 12'hFFF;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [7:0] OUTPUT_MODE_CONTROL_OFS = 8'h01;
   localparam logic [7:0] PWM_FIRST_OFS = 8'h06;
   localparam logic [7:0] PWM_LAST_OFS = 8'h45;
   localparam logic [7:0] ALL_FIRST_OFS = 8'hFA;
   localparam logic [7:0] ALL_LAST_OFS = 8'hFD;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int MODE_INVERT_BIT = 4;
   localparam int MODE_CHANGE_BIT = 3;
   localparam int MODE_DRIVE_BIT = 2;
   localparam int MODE_DIS_LSB = 0;
   localparam logic [7:0] MODE_WR_MASK = 8'h1F;
   localparam logic [7:0] MODE_RST = 8'h04;
   localparam int FULL_BIT = 4;
   localparam logic [7:0] HIGH_BYTE_MASK = 8'h1F;
   localparam logic [7:0] OFF_HIGH_RST = 8'h10;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef struct packed {
      logic full_on;
      logic [11:0] on_cnt;
      logic full_off;
      logic [11:0] off_cnt;
   } mcpwm_chan_cfg_type;

   typedef struct packed {
      logic invert;
      logic totem;
      logic [1:0] dis_state;
   } mcpwm_mode_type;

   typedef struct packed {
      logic [15:0] level;
      logic [15:0] drive_en;
   } mcpwm_pins_type;
endpackage

//--- hdl/mcpwm_output.sv
/*
 * Sixteen channel phase-shifted PWM generator with output mode control.
 * Register writes arrive from the serial-bus slave on mclk_i; the counter
 * and the channel pins run on pwm_clk_i (oscillator or prescaled clock),
 * which may stop in sleep. Pins oe_n_i and osc_sleep_i are asynchronous.
 */
module mcpwm_output #(
   parameter int NUM_CH = mcpwm_pkg::NUM_CH
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic pwm_clk_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic bus_stop_i,
   output logic [7:0] reg_rdata_o,
   input wire logic oe_n_i,
   input wire logic osc_sleep_i,
   output mcpwm_pkg::mcpwm_pins_type channel_output_o
);
   localparam int NB = NUM_CH * mcpwm_pkg::BYTES_PER_CH;

   // ==========================================================
   // Decoding helpers
   // ==========================================================
   function automatic logic is_pwm(input logic [7:0] a);
      is_pwm = (a >= mcpwm_pkg::PWM_FIRST_OFS) && (a <= mcpwm_pkg::PWM_LAST_OFS);
   endfunction

   function automatic logic is_all(input logic [7:0] a);
      is_all = (a >= mcpwm_pkg::ALL_FIRST_OFS) && (a <= mcpwm_pkg::ALL_LAST_OFS);
   endfunction

   function automatic logic [7:0] wmask(input logic [1:0] k, input logic [7:0] d);
      wmask = k[0] ? (d & mcpwm_pkg::HIGH_BYTE_MASK) : d;
   endfunction

   function automatic mcpwm_pkg::mcpwm_chan_cfg_type to_cfg(input logic [31:0] b);
      to_cfg.on_cnt = {b[11:8], b[7:0]};
      to_cfg.full_on = b[8 + mcpwm_pkg::FULL_BIT];
      to_cfg.off_cnt = {b[27:24], b[23:16]};
      to_cfg.full_off = b[24 + mcpwm_pkg::FULL_BIT];
   endfunction

   function automatic mcpwm_pkg::mcpwm_mode_type to_mode(input logic [7:0] m);
      to_mode.invert = m[mcpwm_pkg::MODE_INVERT_BIT];
      to_mode.totem = m[mcpwm_pkg::MODE_DRIVE_BIT];
      to_mode.dis_state = m[mcpwm_pkg::MODE_DIS_LSB +: 2];
   endfunction

   // ==========================================================
   // Register file (mclk domain)
   // ==========================================================
   logic [7:0] mode_ff;
   logic [7:0] stg_ff [NB];
   logic [3:0] ld_ff [NUM_CH];
   logic [NUM_CH-1:0] nxt_commit;
   logic [NUM_CH-1:0] commit_ff;
   logic stop_dirty_ff;
   logic [7:0] pidx;
   logic [1:0] wr_k;
   logic wr_pwm;
   logic wr_all;
   logic output_change_select;

   assign pidx = reg_addr_i - mcpwm_pkg::PWM_FIRST_OFS;
   assign wr_k = reg_addr_i[1:0] - mcpwm_pkg::ALL_FIRST_OFS[1:0];
   assign wr_pwm = reg_wr_i && is_pwm(reg_addr_i);
   assign wr_all = reg_wr_i && is_all(reg_addr_i);
   assign output_change_select = mode_ff[mcpwm_pkg::MODE_CHANGE_BIT];

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mode_ff <= mcpwm_pkg::MODE_RST;
      end else if (reg_wr_i && reg_addr_i == mcpwm_pkg::OUTPUT_MODE_CONTROL_OFS) begin
         mode_ff <= reg_wdata_i & mcpwm_pkg::MODE_WR_MASK;
      end
   end

   // Staged bytes are what the host sees; the generator only sees committed copies
   always_ff @(posedge mclk_i) begin
      for (int i = 0; i < NB; i++) begin
         if (sys_rst_i) begin
            stg_ff[i] <= (i % 4 == 3) ? mcpwm_pkg::OFF_HIGH_RST : mcpwm_pkg::BYTE_RST;
         end else if (wr_pwm && pidx[5:0] == i[5:0]) begin
            stg_ff[i] <= wmask(pidx[1:0], reg_wdata_i);
         end else if (wr_all && wr_k == i[1:0]) begin
            stg_ff[i] <= wmask(wr_k, reg_wdata_i); // see [R17]
         end
      end
   end

   // Any PWM byte write with change select 0 arms the STOP update
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         stop_dirty_ff <= 1'b0;
      end else if ((wr_pwm || wr_all) && !output_change_select) begin
         stop_dirty_ff <= 1'b1; // see [R6]
      end else if (bus_stop_i) begin
         stop_dirty_ff <= 1'b0;
      end
   end

   // Per-channel loaded-byte tracking for acknowledge mode
   always_comb begin
      nxt_commit = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (!output_change_select) begin
            nxt_commit[c] = bus_stop_i && stop_dirty_ff; // see [R3]
         end else begin
            nxt_commit[c] = &(ld_ff[c] | ((wr_pwm && pidx[5:2] == c[3:0]) ? 
               4'h1 << pidx[1:0] : 4'h0) | (wr_all ? 4'h1 << wr_k : 4'h0)); // see [R4] [R5]
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (sys_rst_i || !output_change_select || nxt_commit[c]) begin
            ld_ff[c] <= 4'h0;
         end else if (wr_pwm && pidx[5:2] == c[3:0]) begin
            ld_ff[c] <= ld_ff[c] | (4'h1 << pidx[1:0]);
         end else if (wr_all) begin
            ld_ff[c] <= ld_ff[c] | (4'h1 << wr_k);
         end
      end
   end

   // Commit one cycle late so the acknowledged byte is already staged
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         commit_ff <= '0;
      end else begin
         commit_ff <= nxt_commit;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_addr_i == mcpwm_pkg::OUTPUT_MODE_CONTROL_OFS) begin
         reg_rdata_o <= mode_ff;
      end else if (is_pwm(reg_addr_i)) begin
         reg_rdata_o <= stg_ff[pidx[5:0]];
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // ==========================================================
   // Committed values and toggle handshake toward pwm_clk_i
   // ==========================================================
   mcpwm_pkg::mcpwm_chan_cfg_type act_ff [NUM_CH];
   mcpwm_pkg::mcpwm_chan_cfg_type xfer_ff [NUM_CH];
   logic req_ff;
   logic ack_s1_ff;
   logic ack_s2_ff;
   logic dirty_ff;
   logic launch;
   logic ack_s1_ff_src;
   logic mode_wr;
   mcpwm_pkg::mcpwm_mode_type mode_x_ff;

   always_ff @(posedge mclk_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (sys_rst_i) begin
            act_ff[c] <= to_cfg({mcpwm_pkg::OFF_HIGH_RST, 24'h0});
         end else if (commit_ff[c]) begin
            act_ff[c] <= to_cfg({stg_ff[4*c+3], stg_ff[4*c+2], stg_ff[4*c+1], stg_ff[4*c]});
         end
      end
   end

   // Transfer words stay frozen until the far side returns the toggle
   assign launch = dirty_ff && (req_ff == ack_s2_ff);
   assign mode_wr = reg_wr_i && (reg_addr_i == mcpwm_pkg::OUTPUT_MODE_CONTROL_OFS);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dirty_ff <= 1'b0;
      end else if (commit_ff != '0 || mode_wr) begin
         dirty_ff <= 1'b1;
      end else if (launch) begin
         dirty_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         req_ff <= 1'b0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
      end else begin
         req_ff <= req_ff ^ launch;
         ack_s1_ff <= ack_s1_ff_src;
         ack_s2_ff <= ack_s1_ff;
      end
   end

   always_ff @(posedge mclk_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (sys_rst_i) begin
            xfer_ff[c] <= to_cfg({mcpwm_pkg::OFF_HIGH_RST, 24'h0});
         end else if (launch) begin
            xfer_ff[c] <= act_ff[c];
         end
      end
   end

   // Mode bits cross as one word so inversion and drive never mix old and new
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mode_x_ff <= to_mode(mcpwm_pkg::MODE_RST);
      end else if (launch) begin
         mode_x_ff <= to_mode(mode_ff);
      end
   end

   // ==========================================================
   // PWM domain: synchronisers
   // ==========================================================
   logic rst_s1_ff;
   logic pwm_rst_ff;
   logic req_s1_ff;
   logic req_s2_ff;
   logic req_s3_ff;
   logic [1:0] pin_s1_ff;
   logic [1:0] pin_s2_ff;
   mcpwm_pkg::mcpwm_mode_type md_ff;
   mcpwm_pkg::mcpwm_mode_type md;
   logic oe_n_s;
   logic sleep_s;

   assign ack_s1_ff_src = req_s3_ff;

   always_ff @(posedge pwm_clk_i) begin
      rst_s1_ff <= sys_rst_i;
      pwm_rst_ff <= rst_s1_ff;
   end

   // Beside reset and the request toggle, only the two pins are single-bit synchronised; mode rides the handshake
   always_ff @(posedge pwm_clk_i) begin
      pin_s1_ff <= {osc_sleep_i, oe_n_i};
      pin_s2_ff <= pin_s1_ff;
   end

   always_ff @(posedge pwm_clk_i) begin
      if (pwm_rst_ff) begin
         md_ff <= to_mode(mcpwm_pkg::MODE_RST);
      end else if (req_s2_ff != req_s3_ff) begin
         md_ff <= mode_x_ff;
      end
   end

   assign md = md_ff;
   assign oe_n_s = pin_s2_ff[0];
   assign sleep_s = pin_s2_ff[1];

   always_ff @(posedge pwm_clk_i) begin
      if (pwm_rst_ff) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         req_s3_ff <= 1'b0;
      end else begin
         req_s1_ff <= req_ff;
         req_s2_ff <= req_s1_ff;
         req_s3_ff <= req_s2_ff;
      end
   end

   // ==========================================================
   // PWM domain: counter, compare and pin drive
   // ==========================================================
   mcpwm_pkg::mcpwm_chan_cfg_type cfg_ff [NUM_CH];
   logic [mcpwm_pkg::CNT_W-1:0] cnt_ff;
   logic [NUM_CH-1:0] lvl_ff;

   always_ff @(posedge pwm_clk_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (pwm_rst_ff) begin
            cfg_ff[c] <= to_cfg({mcpwm_pkg::OFF_HIGH_RST, 24'h0});
         end else if (req_s2_ff != req_s3_ff) begin
            cfg_ff[c] <= xfer_ff[c];
         end
      end
   end

   always_ff @(posedge pwm_clk_i) begin
      if (pwm_rst_ff) begin
         cnt_ff <= '0;
      end else if (!sleep_s) begin
         cnt_ff <= (cnt_ff == mcpwm_pkg::CNT_LAST) ? '0 : cnt_ff + 1'b1; // see [R12] [R14] [R16]
      end
   end

   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         always_ff @(posedge pwm_clk_i) begin
            if (pwm_rst_ff) begin
               lvl_ff[c] <= 1'b0;
            end else if (sleep_s) begin
               lvl_ff[c] <= lvl_ff[c]; // see [R16]
            end else if (cfg_ff[c].full_off) begin
               lvl_ff[c] <= 1'b0; // see [R17] [R18]
            end else if (cfg_ff[c].full_on) begin
               lvl_ff[c] <= 1'b1; // see [R18]
            end else if (cnt_ff == cfg_ff[c].off_cnt) begin
               lvl_ff[c] <= 1'b0; // see [R13] [R19]
            end else if (cnt_ff == cfg_ff[c].on_cnt) begin
               lvl_ff[c] <= 1'b1; // see [R10] [R11] [R13] [R15]
            end
         end

         always_ff @(posedge pwm_clk_i) begin
            if (pwm_rst_ff) begin
               channel_output_o.level[c] <= 1'b0; // see [R9]
               channel_output_o.drive_en[c] <= 1'b1;
            end else if (!oe_n_s) begin
               if (md.totem) begin
                  channel_output_o.level[c] <= lvl_ff[c] ^ md.invert; // see [R1] [R2]
                  channel_output_o.drive_en[c] <= 1'b1;
               end else begin
                  channel_output_o.level[c] <= 1'b0; // see [R7]
                  channel_output_o.drive_en[c] <= !(lvl_ff[c] ^ md.invert);
               end
            end else begin
               channel_output_o.level[c] <= (md.dis_state == 2'b01) && md.totem; // see [R8]
               channel_output_o.drive_en[c] <= (md.dis_state == 2'b00) ||
                  ((md.dis_state == 2'b01) && md.totem);
            end
         end
      end
   endgenerate
endmodule

//--- dv/mcpwm_host_model.sv
/* Serial-bus host model: acknowledged byte writes, STOP and read-back.
   Assumes the block samples its bus inputs on rising mclk_i. */
module mcpwm_host_model (
   input wire logic mclk_i,
   output logic reg_wr_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic bus_stop_o,
   input wire logic [7:0] reg_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      bus_stop_o = 1'b0;
   end
   // ==========
   // Bus cycles
   // ==========
   // In acknowledge mode callers send every byte of a channel before relying on the result
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      reg_wr_o = 1'b1;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(negedge mclk_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d;
   endtask
   // Any number of bytes, in any order, may precede this
   task automatic stop();
      @(negedge mclk_i);
      bus_stop_o = 1'b1;
      @(negedge mclk_i);
      bus_stop_o = 1'b0;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk_i);
      reg_addr_o = a;
      repeat (2) @(negedge mclk_i);
      d = reg_rdata_i;
   endtask
endmodule

//--- dv/mcpwm_output_properties.sv
/* Port checker of the PWM output block.
   Assumes it is bound to mcpwm_output and sees only its ports. */
module mcpwm_output_checker (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic pwm_clk_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic oe_n_i,
   input wire logic osc_sleep_i,
   input wire mcpwm_pkg::mcpwm_pins_type channel_output_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wmask_ff;
   // High bytes keep only five bits
   always_ff @(posedge mclk_i) wmask_ff <= reg_addr_i[0] ? 8'h1F : 8'hFF;
   // ==========
   // Properties
   // ==========
   a_reset_pins:
      assert property (@(posedge pwm_clk_i) sys_rst_i [*4] |->
         channel_output_o == 32'h0000FFFF) else $error("pins not low in reset");
   a_reset_rdata:
      assert property (@(posedge mclk_i) sys_rst_i |=> reg_rdata_o == 8'h00)
      else $error("read data not cleared by reset");
   a_unmapped_read:
      assert property (@(posedge mclk_i) disable iff (sys_rst_i)
         reg_addr_i inside {8'h00, [8'h02:8'h05], [8'h46:8'hFF]} |=> reg_rdata_o == 8'h00)
      else $error("unmapped address read nonzero");
   a_reserved_zero:
      assert property (@(posedge mclk_i) disable iff (sys_rst_i)
         (reg_addr_i == 8'h01 || (reg_addr_i inside {[8'h06:8'h45]} && reg_addr_i[0]))
         |=> reg_rdata_o[7:5] == 3'h0) else $error("reserved bits read nonzero");
   a_mode_readback:
      assert property (@(posedge mclk_i) disable iff (sys_rst_i)
         (reg_wr_i && reg_addr_i == 8'h01) ##1 reg_addr_i == 8'h01
         |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h1F)) else $error("mode readback");
   a_byte_readback:
      assert property (@(posedge mclk_i) disable iff (sys_rst_i)
         (reg_wr_i && reg_addr_i inside {[8'h06:8'h45]}) ##1 $stable(reg_addr_i)
         |=> reg_rdata_o == ($past(reg_wdata_i, 2) & wmask_ff)) else $error("byte readback");
   a_disabled_uniform:
      assert property (@(posedge pwm_clk_i) disable iff (sys_rst_i) oe_n_i [*5] |->
         (channel_output_o.level == 16'h0000 || channel_output_o.level == 16'hFFFF) &&
         (channel_output_o.drive_en == 16'h0000 || channel_output_o.drive_en == 16'hFFFF))
      else $error("disabled outputs differ");
   a_sleep_frozen:
      assert property (@(posedge pwm_clk_i) disable iff (sys_rst_i) osc_sleep_i [*6] |=>
         $stable(channel_output_o)) else $error("outputs moved in sleep");
endmodule

bind mcpwm_output mcpwm_output_checker chk (.mclk_i, .sys_rst_i, .pwm_clk_i, .reg_wr_i,
   .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .oe_n_i, .osc_sleep_i, .channel_output_o);

//--- dv/mcpwm_output_bench.sv
/* Self-checking bench of the PWM output block.
   Assumes the host model drives the bus side; OE and sleep come from here. */
module mcpwm_output_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic pwm_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic oe_n_i = 1'b0;
   logic osc_sleep_i = 1'b0;
   logic reg_wr_i, bus_stop_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
   mcpwm_pkg::mcpwm_pins_type channel_output_o;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   initial forever #4 mclk_i = ~mclk_i;
   initial begin
      #3;
      forever #80 pwm_clk_i = ~pwm_clk_i;
   end
   mcpwm_output dut (.mclk_i, .sys_rst_i, .pwm_clk_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
      .bus_stop_i, .reg_rdata_o, .oe_n_i, .osc_sleep_i, .channel_output_o);
   mcpwm_host_model host (.mclk_i, .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .bus_stop_o(bus_stop_i), .reg_rdata_i(reg_rdata_o));
   // ==========
   // Helpers
   // ==========
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One PWM period is about 82000 cycles and the first wait may take one
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 120000) begin
         errors++;
         test_done();
      end
   end
   // Covers the toggle crossing plus the pin pipeline
   task automatic settle();
      repeat (24) @(posedge pwm_clk_i);
      @(negedge mclk_i);
   endtask
   function automatic logic [3:0] pins2();
      return {channel_output_o.drive_en[1:0], channel_output_o.level[1:0]};
   endfunction
   task automatic mode(input logic [7:0] m);
      host.write(8'h01, m);
      settle();
   endtask
   task automatic set_ch(input int ch, input logic [12:0] on, input logic [12:0] off);
      host.write(8'(6 + 4 * ch), on[7:0]);
      host.write(8'(7 + 4 * ch), {3'h0, on[12:8]});
      host.write(8'(8 + 4 * ch), off[7:0]);
      host.write(8'(9 + 4 * ch), {3'h0, off[12:8]});
   endtask
   // ==========
   // Scenarios
   // ==========
   task automatic t_reset();
      check("pins", channel_output_o, 32'h0000FFFF);
      host.read(8'h01, rd);
      check("mode", rd, 32'h04);
      host.read(8'h09, rd);
      check("off high", rd, 32'h10);
      host.read(8'h02, rd);
      check("unmapped", rd, 32'h00);
   endtask
   task automatic t_pwm();
      int w, n1, n2;
      set_ch(0, 13'h0FF0, 13'h0010);
      set_ch(1, 13'h0FF4, 13'h0FF4);
      set_ch(2, 13'h0000, 13'h0008);
      set_ch(3, 13'h0FEC, 13'h0010);
      settle();
      check("before stop", channel_output_o.level, 32'h0);
      host.stop();
      w = 0;
      while (channel_output_o.level[0] !== 1'b1 && w < 4200) begin
         @(negedge pwm_clk_i);
         w++;
      end
      check("lead channel", channel_output_o.level[3], 32'h1);
      w = 0;
      n1 = 0;
      n2 = 0;
      while (channel_output_o.level[0] === 1'b1 && w < 64) begin
         n1 += channel_output_o.level[1];
         n2 += channel_output_o.level[2];
         @(negedge pwm_clk_i);
         w++;
      end
      check("width", w, 32);
      check("equal counts", n1, 0);
      check("after wrap", n2, 8);
      check("lead off", channel_output_o.level[3], 32'h0);
   endtask
   task automatic t_modes();
      logic [7:0] md [5] = '{8'h04, 8'h05, 8'h01, 8'h06, 8'h07};
      logic [3:0] ex [5] = '{4'hC, 4'hF, 4'h0, 4'h0, 4'h0};
      logic [3:0] p;
      set_ch(0, 13'h1000, 13'h0000);
      host.stop();
      settle();
      check("full on", pins2(), 4'hD);
      mode(8'h14);
      check("inverted", pins2(), 4'hE);
      mode(8'h10);
      check("open drain", pins2(), 4'h4);
      mode(8'h04);
      check("plain", pins2(), 4'hD);
      oe_n_i = 1'b1;
      foreach (md[i]) begin
         mode(md[i]);
         p = pins2();
         check("disabled", p & {2'b11, p[3:2]}, ex[i]);
      end
      oe_n_i = 1'b0;
      host.write(8'h09, 8'h10);
      host.stop();
      settle();
      check("off wins", pins2(), 4'hC);
   endtask
   task automatic t_ack();
      mode(8'h0C);
      host.write(8'h09, 8'h00);
      host.write(8'h06, 8'h00);
      host.write(8'h08, 8'h00);
      settle();
      check("partial", pins2(), 4'hC);
      host.write(8'h07, 8'h10);
      settle();
      check("ack", pins2(), 4'hD);
      mode(8'h04);
      host.write(8'hFD, 8'h10);
      host.stop();
      settle();
      check("all off", channel_output_o, 32'h0000FFFF);
   endtask
   task automatic t_sleep();
      host.write(8'h09, 8'h00);
      host.stop();
      settle();
      check("single byte", pins2(), 4'hD);
      osc_sleep_i = 1'b1;
      settle();
      host.write(8'h09, 8'h10);
      host.stop();
      settle();
      check("asleep", pins2(), 4'hD);
      osc_sleep_i = 1'b0;
      settle();
      check("awake", pins2(), 4'hC);
   endtask
   initial begin
      repeat (16) @(posedge pwm_clk_i);
      @(negedge mclk_i);
      sys_rst_i = 1'b0;
      t_reset();
      t_pwm();
      t_modes();
      t_ack();
      t_sleep();
      test_done();
   end
endmodule
